//--- hdl/rpt_pkg.sv
// constants, register map and state type for the reset, park and test-point control block
package rpt_pkg;

    // clock and timing
    localparam int CLK_FREQ_MHZ = 125;
    localparam int SAMPLE_DELAY_NS = 1500;
    // least time, so the cycle count rounds up
    localparam int SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int CONFIG_CYC = 64;
    localparam int PARK_CYC = 32;
    localparam int CNT_W = 16;

    // test-point pins
    localparam int TP_W = 8;
    localparam logic [TP_W-1:0] TP_ALL_ON = 8'hFF;
    localparam logic [TP_W-1:0] TP_ALL_OFF = 8'h00;

    // register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;

    // ctrl fields
    localparam int CTRL_TP_VALUE_LSB = 0;
    localparam logic [TP_W-1:0] CTRL_RESET = 8'h00;

    // status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_POR_BIT = 3;
    localparam int STAT_PARK_BIT = 4;
    localparam int STAT_MFG_BIT = 5;
    localparam int STAT_SCAN_BIT = 6;
    localparam int STAT_MODE_LSB = 8;

    // sequencer states
    typedef enum logic [2:0] {
        ST_RESET,
        ST_WAIT,
        ST_SAMPLE,
        ST_CONFIG,
        ST_RUN,
        ST_PARK,
        ST_PARKED
    } seq_state_e;

endpackage

//--- hdl/pin_sync2.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // asynchronous level in, synchronised level out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            meta_r <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule // pin_sync2

//--- hdl/reset_park_testmode_control.sv
// reset release sequencing, test-point sampling and fast park control with apb registers
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module reset_park_testmode_control #(
    parameter int SAMPLE_CYC = rpt_pkg::SAMPLE_DELAY_CYC,
    parameter int CONFIG_CYC = rpt_pkg::CONFIG_CYC,
    parameter int PARK_CYC = rpt_pkg::PARK_CYC
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // control pins from the power manager
    input wire logic power_on_reset_low_i,
    input wire logic fast_park_request_low_i,
    input wire logic manufacturing_test_enable_i,
    input wire logic internal_scan_reset_i,
    // test-point pins (two-way)
    input wire logic [rpt_pkg::TP_W-1:0] test_point_pins_i,
    output logic [rpt_pkg::TP_W-1:0] test_point_pins_o,
    output logic [rpt_pkg::TP_W-1:0] test_point_pins_oe_o,
    output logic [rpt_pkg::TP_W-1:0] test_point_pulldown_en_o,
    // sequencer results
    output logic config_start_o,
    output logic config_busy_o,
    output logic config_done_o,
    output logic [rpt_pkg::TP_W-1:0] test_mode_o,
    output logic mirror_fast_park_o,
    output logic mirror_parked_o,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [rpt_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic por_q;
    logic park_q;
    logic mfg_q;
    logic scan_q;
    logic [rpt_pkg::TP_W-1:0] tp_q;

    // reset pin treated as asserted until it has been seen high twice
    pin_sync2 #(.W(1), .RST_VAL(1'b0)) u_sync_por (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .d_i(power_on_reset_low_i),
        .q_o(por_q)
    );

    // park request idles high
    pin_sync2 #(.W(1), .RST_VAL(1'b1)) u_sync_park (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .d_i(fast_park_request_low_i),
        .q_o(park_q)
    );

    // strap-like levels only shown in status
    pin_sync2 #(.W(2), .RST_VAL(2'h0)) u_sync_misc (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .d_i({internal_scan_reset_i, manufacturing_test_enable_i}),
        .q_o({scan_q, mfg_q})
    );

    // test pins; undriven pins read low through the pulldowns
    pin_sync2 #(.W(rpt_pkg::TP_W), .RST_VAL(rpt_pkg::TP_ALL_OFF)) u_sync_tp (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .d_i(test_point_pins_i),
        .q_o(tp_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // reset release detection

    logic por_prev_r;
    logic por_rise;

    // previous synchronised level, for the edge detector
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            por_prev_r <= 1'b0;
        end else begin
            por_prev_r <= por_q;
        end
    end

    assign por_rise = por_q & ~por_prev_r;

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    rpt_pkg::seq_state_e state_r;
    rpt_pkg::seq_state_e state_nxt;
    logic [rpt_pkg::CNT_W-1:0] cnt_r;
    logic park_req;
    logic tp_driven;

    assign park_req = ~park_q;

    // next state; the reset pin overrides everything else
    always_comb begin
        state_nxt = state_r;
        if (!por_q) begin
            state_nxt = rpt_pkg::ST_RESET;
        end else begin
            case (state_r)
                rpt_pkg::ST_RESET: begin
                    if (por_rise) begin
                        state_nxt = rpt_pkg::ST_WAIT;
                    end
                end
                rpt_pkg::ST_WAIT: begin
                    if (park_req) begin
                        state_nxt = rpt_pkg::ST_PARK;
                    end else if (cnt_r == rpt_pkg::CNT_W'(SAMPLE_CYC - 1)) begin
                        state_nxt = rpt_pkg::ST_SAMPLE;
                    end
                end
                rpt_pkg::ST_SAMPLE: begin
                    if (park_req) begin
                        state_nxt = rpt_pkg::ST_PARK;
                    end else begin
                        state_nxt = rpt_pkg::ST_CONFIG;
                    end
                end
                rpt_pkg::ST_CONFIG: begin
                    if (park_req) begin
                        state_nxt = rpt_pkg::ST_PARK;
                    end else if (cnt_r == rpt_pkg::CNT_W'(CONFIG_CYC - 1)) begin
                        state_nxt = rpt_pkg::ST_RUN;
                    end
                end
                rpt_pkg::ST_RUN: begin
                    if (park_req) begin
                        state_nxt = rpt_pkg::ST_PARK;
                    end
                end
                rpt_pkg::ST_PARK: begin
                    if (cnt_r == rpt_pkg::CNT_W'(PARK_CYC - 1)) begin
                        state_nxt = rpt_pkg::ST_PARKED;
                    end
                end
                // parked until the next power-on reset, since power is about to go
                rpt_pkg::ST_PARKED: begin
                    state_nxt = rpt_pkg::ST_PARKED;
                end
                default: begin
                    state_nxt = rpt_pkg::ST_RESET;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_r <= rpt_pkg::ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // dwell counter restarts on every state change
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
        end else if (state_nxt != state_r) begin
            cnt_r <= '0;
        end else if (cnt_r != '1) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    logic [rpt_pkg::TP_W-1:0] ctrl_r;
    logic apb_write;
    logic apb_setup;

    assign apb_setup = psel_i & ~penable_i;
    assign apb_write = psel_i & penable_i & pready_o & pwrite_i;

    // ctrl: value driven on the test pins once they become outputs
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ctrl_r <= rpt_pkg::CTRL_RESET;
        end else if (apb_write && paddr_i == rpt_pkg::ADDR_CTRL && pstrb_i[0]) begin
            ctrl_r <= pwdata_i[rpt_pkg::CTRL_TP_VALUE_LSB +: rpt_pkg::TP_W];
        end
    end

    // one access cycle, no wait states: ready rises in the cycle after setup
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= apb_setup;
        end
    end

    // read data and error captured at the setup edge, stable through access
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (apb_setup) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            case (paddr_i)
                rpt_pkg::ADDR_CTRL: begin
                    if (!pwrite_i) begin
                        prdata_o[rpt_pkg::CTRL_TP_VALUE_LSB +: rpt_pkg::TP_W] <= ctrl_r;
                    end
                end
                rpt_pkg::ADDR_STATUS: begin
                    if (!pwrite_i) begin
                        prdata_o[rpt_pkg::STAT_STATE_LSB +: 3] <= state_r;
                        prdata_o[rpt_pkg::STAT_POR_BIT] <= por_q;
                        prdata_o[rpt_pkg::STAT_PARK_BIT] <= park_q;
                        prdata_o[rpt_pkg::STAT_MFG_BIT] <= mfg_q;
                        prdata_o[rpt_pkg::STAT_SCAN_BIT] <= scan_q;
                        prdata_o[rpt_pkg::STAT_MODE_LSB +: rpt_pkg::TP_W] <= test_mode_o;
                    end
                end
                // unmapped addresses answer with an error and zero data
                default: begin
                    pslverr_o <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // test-point pins

    // pins turn to outputs after the sample has been taken, or on a park request from ST_WAIT before any sample
    assign tp_driven = (state_nxt == rpt_pkg::ST_CONFIG) || (state_nxt == rpt_pkg::ST_RUN)
        || (state_nxt == rpt_pkg::ST_PARK) || (state_nxt == rpt_pkg::ST_PARKED);

    // output enables low in reset keep the pins high impedance
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            test_point_pins_oe_o <= rpt_pkg::TP_ALL_OFF;
            test_point_pins_o <= rpt_pkg::TP_ALL_OFF;
        end else if (tp_driven) begin
            test_point_pins_oe_o <= rpt_pkg::TP_ALL_ON;
            test_point_pins_o <= ctrl_r;
        end else begin
            test_point_pins_oe_o <= rpt_pkg::TP_ALL_OFF;
            test_point_pins_o <= rpt_pkg::TP_ALL_OFF;
        end
    end

    // pulldowns are passive and stay on even in reset, so open pins read low
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            test_point_pulldown_en_o <= rpt_pkg::TP_ALL_ON;
        end else begin
            test_point_pulldown_en_o <= rpt_pkg::TP_ALL_ON;
        end
    end

    // test mode selection latched once per release; a high pin selects a mode
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            test_mode_o <= rpt_pkg::TP_ALL_OFF;
        end else if (!por_q) begin
            test_mode_o <= rpt_pkg::TP_ALL_OFF;
        end else if (state_r == rpt_pkg::ST_SAMPLE) begin
            test_mode_o <= tp_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer outputs

    // start pulse in the cycle after release is seen
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            config_start_o <= 1'b0;
        end else begin
            config_start_o <= (state_r == rpt_pkg::ST_RESET)
                && (state_nxt == rpt_pkg::ST_WAIT);
        end
    end

    // configuration progress levels, all low while the reset pin is low
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            config_busy_o <= 1'b0;
            config_done_o <= 1'b0;
        end else begin
            config_busy_o <= (state_nxt == rpt_pkg::ST_WAIT)
                || (state_nxt == rpt_pkg::ST_SAMPLE)
                || (state_nxt == rpt_pkg::ST_CONFIG);
            config_done_o <= (state_nxt == rpt_pkg::ST_RUN);
        end
    end

    // fast park drive, then parked indication; only the reset pin going low aborts the park
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            mirror_fast_park_o <= 1'b0;
            mirror_parked_o <= 1'b0;
        end else begin
            mirror_fast_park_o <= (state_nxt == rpt_pkg::ST_PARK);
            mirror_parked_o <= (state_nxt == rpt_pkg::ST_PARKED);
        end
    end

endmodule // reset_park_testmode_control

//--- tb/pmic_model.sv
// power manager and board model: reset and park pins, test-point straps
`timescale 1ns/1ps
module pmic_model (
    // clock
    input wire logic clock_i,
    // test-point drive from the block
    input wire logic [7:0] tp_oe_i,
    input wire logic [7:0] tp_out_i,
    input wire logic [7:0] tp_pd_i,
    // pins towards the block
    output logic por_low_o,
    output logic park_low_o,
    output logic mfg_en_o,
    output logic scan_rst_o,
    output logic [7:0] tp_level_o
);
    logic [7:0] strap_r = 8'h00;
    logic [7:0] last_r = 8'h00;
    // power comes up with reset held; test straps stay grounded
    initial begin
        por_low_o = 1'b0;
        park_low_o = 1'b1;
        mfg_en_o = 1'b0;
        scan_rst_o = 1'b0;
    end
    // pins change just after an edge, as a clocked supervisor would
    task automatic drive(input logic por, input logic park, input logic [7:0] strap);
        @(posedge clock_i);
        por_low_o <= por;
        park_low_o <= park;
        strap_r <= strap;
    endtask
    // a floating pin with no pulldown wanders instead of keeping its level
    always @(posedge clock_i) last_r <= tp_level_o;
    assign tp_level_o = (tp_oe_i & tp_out_i) | (~tp_oe_i & strap_r)
        | (~tp_oe_i & ~strap_r & ~tp_pd_i & ~last_r);
endmodule // pmic_model

//--- tb/rpt_asserts.sv
// assertions on the ports of the reset, park and test-point control block
`timescale 1ns/1ps
module rpt_checker #(
    parameter int SAMPLE_CYC = 188,
    parameter int CONFIG_CYC = 64,
    parameter int PARK_CYC = 32
) (
    // clock and reset
    input wire logic clock_i, rst_b_i,
    // control pins
    input wire logic power_on_reset_low_i, fast_park_request_low_i,
    input wire logic manufacturing_test_enable_i, internal_scan_reset_i,
    // test-point pins
    input wire logic [7:0] test_point_pins_i, test_point_pins_o,
    input wire logic [7:0] test_point_pins_oe_o, test_point_pulldown_en_o,
    // sequencer results
    input wire logic config_start_o, config_busy_o, config_done_o,
    input wire logic [7:0] test_mode_o,
    input wire logic mirror_fast_park_o, mirror_parked_o,
    // apb
    input wire logic psel_i, penable_i, pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic [3:0] pstrb_i,
    input wire logic pready_o, pslverr_o
);
    localparam int SHI = SAMPLE_CYC + 3;
    localparam int PLO = PARK_CYC - 1;
    localparam int PHI = PARK_CYC + 1;
    logic [15:0] wait_cnt_r;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////////
    // counts from the start pulse to the pin turnaround; cleared by the reset pin
    always_ff @(posedge clock_i) begin
        if (!rst_b_i || !power_on_reset_low_i) begin
            wait_cnt_r <= 16'h0000;
        end else if (config_start_o) begin
            wait_cnt_r <= 16'h0001;
        end else if (wait_cnt_r != 16'h0000 && test_point_pins_oe_o == 8'h00) begin
            wait_cnt_r <= wait_cnt_r + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // four edges of low reset pin cover the synchroniser and output flops
    sequence s_held_low;
        !power_on_reset_low_i [*4];
    endsequence
    property p_quiet_oe;
        s_held_low |-> test_point_pins_oe_o == 8'h00;
    endproperty
    a_quiet_oe: assert property (p_quiet_oe) else $error("test pins driven in reset");
    property p_quiet_out;
        s_held_low |-> !(config_start_o | config_busy_o | config_done_o | mirror_fast_park_o
            | mirror_parked_o) && test_mode_o == 8'h00 && test_point_pins_o == 8'h00;
    endproperty
    a_quiet_out: assert property (p_quiet_out) else $error("output active in reset");
    property p_pulldown;
        test_point_pulldown_en_o == 8'hFF;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pulldown dropped");
    property p_start;
        config_start_o |=> !config_start_o && config_busy_o;
    endproperty
    a_start: assert property (p_start) else $error("start not a pulse into busy");
    property p_start_cause;
        $rose(config_start_o) |-> $past(power_on_reset_low_i) && $past(power_on_reset_low_i, 2);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without release");
    property p_done;
        $rose(config_done_o) |-> $past(config_busy_o) && !config_busy_o;
    endproperty
    a_done: assert property (p_done) else $error("done not after busy");
    property p_sample_at;
        $rose(test_point_pins_oe_o[0]) |-> wait_cnt_r >= SAMPLE_CYC && wait_cnt_r <= SHI - 1;
    endproperty
    a_sample_at: assert property (p_sample_at) else $error("test pin turnaround off time");
    property p_sample_due;
        config_start_o |-> ##[1:SHI] (test_point_pins_oe_o == 8'hFF || !power_on_reset_low_i);
    endproperty
    a_sample_due: assert property (p_sample_due) else $error("test pins never driven");
    property p_mode_hold;
        test_point_pins_oe_o == 8'hFF && $past(test_point_pins_oe_o) == 8'hFF |-> $stable(test_mode_o);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("test mode changed after sample");
    property p_park_cause;
        $rose(mirror_fast_park_o) |-> !$past(fast_park_request_low_i)
            && !$past(fast_park_request_low_i, 2);
    endproperty
    a_park_cause: assert property (p_park_cause) else $error("park without request");
    property p_park_len;
        $rose(mirror_fast_park_o) |-> ##[PLO:PHI] (mirror_parked_o || !power_on_reset_low_i);
    endproperty
    a_park_len: assert property (p_park_len) else $error("park did not finish in time");
    property p_parked_excl;
        mirror_parked_o |-> !mirror_fast_park_o;
    endproperty
    a_parked_excl: assert property (p_parked_excl) else $error("parked while parking");
    property p_apb;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_apb: assert property (p_apb) else $error("apb access not answered");
endmodule // rpt_checker
bind reset_park_testmode_control rpt_checker #(.SAMPLE_CYC(SAMPLE_CYC),
    .CONFIG_CYC(CONFIG_CYC), .PARK_CYC(PARK_CYC)) rpt_checker_i (.*);

//--- tb/testbench.sv
// self-checking bench for the reset, park and test-point control block
`timescale 1ns/1ps
module testbench;
    localparam int SCYC = 188;
    localparam int CCYC = 4;
    localparam int PCYC = 4;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0] pstrb_i = 4'hF;
    logic power_on_reset_low_i, fast_park_request_low_i, manufacturing_test_enable_i;
    logic internal_scan_reset_i, config_start_o, config_busy_o, config_done_o, er;
    logic mirror_fast_park_o, mirror_parked_o, pready_o, pslverr_o;
    logic [7:0] test_point_pins_i, test_point_pins_o, test_point_pins_oe_o;
    logic [7:0] test_point_pulldown_en_o, test_mode_o;
    int miscompares = 0;
    int checks_done = 0;
    int n;
    always #4 clock_i = ~clock_i;
    reset_park_testmode_control #(.SAMPLE_CYC(SCYC), .CONFIG_CYC(CCYC), .PARK_CYC(PCYC))
        reset_park_testmode_control_i (.*);
    pmic_model pmic_model_i (.clock_i(clock_i), .tp_oe_i(test_point_pins_oe_o),
        .tp_out_i(test_point_pins_o), .tp_pd_i(test_point_pulldown_en_o),
        .por_low_o(power_on_reset_low_i), .park_low_o(fast_park_request_low_i),
        .mfg_en_o(manufacturing_test_enable_i), .scan_rst_o(internal_scan_reset_i),
        .tp_level_o(test_point_pins_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("MISMATCH %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return config_start_o;
            1: return test_point_pins_oe_o[0];
            2: return config_done_o;
            3: return mirror_fast_park_o;
            default: return mirror_parked_o;
        endcase
    endfunction
    // bounded wait on one output; n is the number of edges it took
    task automatic wait_for(input int k);
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pick(k) !== 1'b1 && n < 400);
        if (n >= 400) begin
            miscompares++;
            $display("MISMATCH %0t wait ran out", $time);
            close_out();
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (k >= 20) begin
            miscompares++;
            $display("MISMATCH %0t apb timeout", $time);
            close_out();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // held in reset: quiet outputs, pulldowns on, status and a bad address
    task automatic sc_reset_quiet();
        repeat (4) @(posedge clock_i);
        chk(test_point_pins_oe_o, 8'h00);
        chk({config_start_o, config_busy_o, config_done_o, mirror_fast_park_o,
            mirror_parked_o, test_mode_o}, 32'h0);
        chk(test_point_pulldown_en_o, 8'hFF);
        apb(1'b0, rpt_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'hFFFF, 32'h0010);
        chk({31'h0, er}, 32'h0);
        // unmapped address: error flag and zero data are judged apart
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask
    // release with a strap pattern; check start, sample time, mode and drive
    task automatic sc_release(input logic [7:0] strap, input logic [7:0] val);
        apb(1'b1, rpt_pkg::ADDR_CTRL, {24'h0, val});
        pmic_model_i.drive(1'b1, 1'b1, strap);
        wait_for(0);
        chk_rng(n, 3, 5);
        wait_for(1);
        chk_rng(n, SCYC, SCYC + 2);
        @(posedge clock_i);
        chk(test_mode_o, strap);
        chk(test_point_pins_i, val);
        wait_for(2);
        chk_rng(n, CCYC - 1, CCYC + 2);
        apb(1'b1, rpt_pkg::ADDR_STATUS, 32'hFFFF);
        apb(1'b0, rpt_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'hFFFF, {16'h0, strap, 8'h1C});
    endtask
    // reset pin low again: test pins released; done, parked and test mode back to zero
    task automatic sc_drop();
        pmic_model_i.drive(1'b0, 1'b1, 8'h00);
        repeat (4) @(posedge clock_i);
        chk(test_point_pins_oe_o, 8'h00);
        chk({config_done_o, mirror_parked_o, test_mode_o}, 32'h0);
    endtask
    // fast park while running, then the request goes away
    task automatic sc_park();
        pmic_model_i.drive(1'b1, 1'b0, 8'h00);
        wait_for(3);
        chk_rng(n, 3, 5);
        wait_for(4);
        chk_rng(n, PCYC - 1, PCYC + 1);
        pmic_model_i.drive(1'b1, 1'b1, 8'h00);
        repeat (4) @(posedge clock_i);
        chk({mirror_fast_park_o, mirror_parked_o}, 32'h1);
        apb(1'b0, rpt_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h7, 32'h6);
    endtask
    // park request while held in reset is ignored
    task automatic sc_park_in_reset();
        pmic_model_i.drive(1'b0, 1'b0, 8'h00);
        repeat (8) @(posedge clock_i);
        chk({mirror_fast_park_o, mirror_parked_o}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock_i);
        rst_b_i <= 1'b1;
        sc_reset_quiet();
        sc_release(8'h00, 8'hA5);
        sc_drop();
        sc_release(8'h5A, 8'h3C);
        sc_park();
        sc_drop();
        sc_park_in_reset();
        close_out();
    end
endmodule // testbench
